// ---- rtl/adcc_top.sv ----
// converter channel, reference, clock and sequencing control
//
// Local design decisions: the register offsets and strobed register access.
`default_nettype none
module adcc_top
    import adcc_pkg::*;
#(
    parameter int RC_DIV = RC_DIV_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // power state
    input wire logic sleepMode,
    // converter core
    output logic sampleHold,
    output logic bitStrobe,
    input wire logic [12:0] coreResult,
    output adcc_analog_t analogCtrl,
    // events
    output logic irq,
    output logic wakeReq
);
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} adcc_state_t;

    logic [7:0] ctrl0_reg;
    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    logic [7:0] vref_reg;
    logic [7:0] resHi_reg;
    logic [7:0] resLo_reg;
    logic [7:0] rdata_reg;
    logic doneFlag_reg;
    logic doneEn_reg;
    logic [4:0] fvrCnt_reg;
    logic fixed_ref_ready_reg;
    adcc_state_t state_reg;
    logic [3:0] period_reg;
    logic sleep1_reg;
    logic sleep2_reg;
    logic tick;
    logic run;
    logic periodLast;
    logic convDone;
    logic [2:0] clkSel;
    logic [1:0] prefCode;
    logic [12:0] rawSm;
    logic [15:0] resultFmt;

    assign clkSel = ctrl1_reg[CTRL1_CS_LSB +: 3];
    assign prefCode = ctrl1_reg[CTRL1_PREF_LSB +: 2];

    // sleep level from outside the domain
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sleep1_reg <= 1'b0;
            sleep2_reg <= 1'b0;
        end else begin
            sleep1_reg <= sleepMode;
            sleep2_reg <= sleep1_reg;
        end
    end

    // in sleep, conversion only runs with rc selected
    assign run = (state_reg == ST_CONV) && (!sleep2_reg || clkSel[1:0] == CS_RC_LOW[1:0]);

    adcc_clock_div #(
        .RC_DIV(RC_DIV)
    ) u_div (
        .mclk(mclk),
        .resetn(resetn),
        .run(run),
        .clkSel(clkSel),
        .tick(tick)
    );

    assign periodLast = (period_reg == CONV_PERIODS - 4'd1);
    assign convDone = tick && periodLast;

    // sequencer over bit periods
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            period_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    period_reg <= 4'h0;
                    if (ctrl0_reg[CTRL0_GO_BIT] && ctrl0_reg[CTRL0_ON_BIT]) begin
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (!ctrl0_reg[CTRL0_ON_BIT]) begin
                        state_reg <= ST_IDLE;
                    end else if (convDone) begin
                        state_reg <= ST_DONE;
                    end else if (tick) begin
                        period_reg <= period_reg + 4'd1;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign sampleHold = (state_reg == ST_CONV) && (period_reg == 4'h0);
    assign bitStrobe = tick && (state_reg == ST_CONV);

    // sign-magnitude left aligned or twos complement right aligned
    assign rawSm = coreResult[12] ? 13'(-$signed(coreResult)) : coreResult;
    always_comb begin
        if (ctrl1_reg[CTRL1_FMT_BIT]) begin
            resultFmt = {{3{coreResult[12]}}, coreResult};
        end else begin
            resultFmt = {rawSm[11:0], 3'h0, coreResult[12]};
        end
    end

    // result registers loaded at completion
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            resHi_reg <= 8'h00;
            resLo_reg <= 8'h00;
        end else if (convDone && state_reg == ST_CONV) begin
            resHi_reg <= resultFmt[15:8];
            resLo_reg <= resultFmt[7:0];
        end
    end

    // control registers, go bit clears itself at completion
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl0_reg <= CTRL0_RESET;
            ctrl1_reg <= CTRL1_RESET;
            ctrl2_reg <= CTRL2_RESET;
            vref_reg <= VREF_RESET;
        end else begin
            if (regWr && regAddr == ADDR_CTRL0) begin
                ctrl0_reg <= {1'b0, regWdata[6:0]};
            end else if (state_reg == ST_DONE || (state_reg == ST_CONV && !ctrl0_reg[CTRL0_ON_BIT])) begin
                ctrl0_reg[CTRL0_GO_BIT] <= 1'b0;
            end
            if (regWr && regAddr == ADDR_CTRL1) begin
                ctrl1_reg <= {regWdata[7:4], 1'b0, regWdata[2:0]};
            end
            if (regWr && regAddr == ADDR_CTRL2) begin
                ctrl2_reg <= {4'h0, regWdata[3:0]};
            end
            if (regWr && regAddr == ADDR_VREF) begin
                vref_reg <= {regWdata[7], 1'b0, regWdata[5:0]};
            end
        end
    end

    // fixed reference ready after a settle count
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fvrCnt_reg <= 5'h00;
            fixed_ref_ready_reg <= 1'b0;
        end else if (!vref_reg[VREF_FIXED_REF_ENABLE_BIT]) begin
            fvrCnt_reg <= 5'h00;
            fixed_ref_ready_reg <= 1'b0;
        end else if (fvrCnt_reg == 5'(FVR_SETTLE_CYCLES - 1)) begin
            fixed_ref_ready_reg <= 1'b1;
        end else begin
            fvrCnt_reg <= fvrCnt_reg + 5'd1;
        end
    end

    // done flag and enable; set wins over clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            doneFlag_reg <= 1'b0;
            doneEn_reg <= 1'b0;
        end else begin
            if (convDone && state_reg == ST_CONV) begin
                doneFlag_reg <= 1'b1;
            end else if (regWr && regAddr == ADDR_IRQ_CLR && regWdata[0]) begin
                doneFlag_reg <= 1'b0;
            end
            if (regWr && regAddr == ADDR_IRQ_EN) begin
                doneEn_reg <= regWdata[0];
            end
        end
    end

    assign irq = doneFlag_reg && doneEn_reg;
    assign wakeReq = irq && sleep2_reg;

    // analog controls to the multiplexer and references
    always_comb begin
        analogCtrl.posChannel = ctrl0_reg[CTRL0_CHS_LSB +: 5];
        analogCtrl.negChannel = ctrl2_reg[3:0];
        analogCtrl.singleEnded = (ctrl2_reg[3:0] == CHSN_SINGLE);
        case (prefCode)
            PREF_EXT: analogCtrl.posRef = REF_EXT_SEL;
            PREF_FVR: analogCtrl.posRef = REF_FVR_SEL;
            default: analogCtrl.posRef = REF_SUPPLY_SEL;
        endcase
        analogCtrl.negRefExt = ctrl1_reg[CTRL1_NREF_BIT];
        analogCtrl.tempEnable = vref_reg[VREF_TEMP_SENSE_ENABLE_BIT];
        analogCtrl.tempHighRange = vref_reg[VREF_TEMP_SENSE_ENABLE_BIT] && vref_reg[VREF_TEMP_RANGE_SELECT_BIT];
        analogCtrl.fixedRefEnable = vref_reg[VREF_FIXED_REF_ENABLE_BIT];
    end

    // read data one cycle after strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                ADDR_CTRL0: rdata_reg <= ctrl0_reg;
                ADDR_CTRL1: rdata_reg <= ctrl1_reg;
                ADDR_CTRL2: rdata_reg <= ctrl2_reg;
                ADDR_RES_HI: rdata_reg <= resHi_reg;
                ADDR_RES_LO: rdata_reg <= resLo_reg;
                ADDR_VREF: rdata_reg <= {vref_reg[7], fixed_ref_ready_reg, vref_reg[5:0]};
                ADDR_IRQ_STAT: rdata_reg <= {7'h00, doneFlag_reg};
                ADDR_IRQ_EN: rdata_reg <= {7'h00, doneEn_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign regRdata = rdata_reg;
endmodule
`default_nettype wire

// ---- rtl/adcc_pkg.sv ----
// package of constants and types for the converter channel and clock control
`default_nettype none
package adcc_pkg;
    localparam logic [3:0] ADDR_CTRL0 = 4'h0;
    localparam logic [3:0] ADDR_CTRL1 = 4'h1;
    localparam logic [3:0] ADDR_CTRL2 = 4'h2;
    localparam logic [3:0] ADDR_RES_HI = 4'h3;
    localparam logic [3:0] ADDR_RES_LO = 4'h4;
    localparam logic [3:0] ADDR_VREF = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h8;
    localparam int CTRL0_GO_BIT = 1;
    localparam int CTRL0_ON_BIT = 0;
    localparam int CTRL0_CHS_LSB = 2;
    localparam int CTRL1_FMT_BIT = 7;
    localparam int CTRL1_CS_LSB = 4;
    localparam int CTRL1_NREF_BIT = 2;
    localparam int CTRL1_PREF_LSB = 0;
    localparam int VREF_FIXED_REF_ENABLE_BIT = 7;
    localparam int VREF_RDY_BIT = 6;
    localparam int VREF_TEMP_SENSE_ENABLE_BIT = 5;
    localparam int VREF_TEMP_RANGE_SELECT_BIT = 4;
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] CTRL2_RESET = 8'h0f;
    localparam logic [7:0] VREF_RESET = 8'h00;
    localparam logic [4:0] CHS_TEMP = 5'h1d;
    localparam logic [4:0] CHS_DAC = 5'h1e;
    localparam logic [4:0] CHS_FVR = 5'h1f;
    localparam logic [3:0] CHSN_SINGLE = 4'hf;
    localparam logic [1:0] PREF_SUPPLY = 2'h0;
    localparam logic [1:0] PREF_EXT = 2'h2;
    localparam logic [1:0] PREF_FVR = 2'h3;
    localparam logic [2:0] CS_RC_LOW = 3'h3;
    localparam logic [3:0] CONV_PERIODS = 4'hf;
    localparam int RC_DIV_DEFAULT = 32;
    localparam int FVR_SETTLE_CYCLES = 16;
    typedef enum logic [1:0] {REF_SUPPLY_SEL, REF_EXT_SEL, REF_FVR_SEL} adcc_pref_t;
    typedef struct packed {
        logic [4:0] posChannel;
        logic [3:0] negChannel;
        logic singleEnded;
        adcc_pref_t posRef;
        logic negRefExt;
        logic tempEnable;
        logic tempHighRange;
        logic fixedRefEnable;
    } adcc_analog_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcc_bus_t;
endpackage
`default_nettype wire

// ---- rtl/adcc_clock_div.sv ----
// conversion bit period tick generator, divided system clock or rc tick
`default_nettype none
module adcc_clock_div
    import adcc_pkg::*;
#(
    parameter int RC_DIV = RC_DIV_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // control
    input wire logic run,
    input wire logic [2:0] clkSel,
    // bit period tick
    output logic tick
);
    logic [6:0] cnt_reg;
    logic [6:0] limit;

    // divisor from select code, rc modelled by the RC_DIV divisor on the same counter
    function automatic logic [6:0] div_of(input logic [2:0] sel);
        case (sel)
            3'h0: div_of = 7'd2;
            3'h4: div_of = 7'd4;
            3'h1: div_of = 7'd8;
            3'h5: div_of = 7'd16;
            3'h2: div_of = 7'd32;
            3'h6: div_of = 7'd64;
            default: div_of = 7'(RC_DIV);
        endcase
    endfunction

    assign limit = div_of(clkSel) - 7'd1;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 7'h00;
        end else if (!run || cnt_reg >= limit) begin
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 7'd1;
        end
    end

    assign tick = run && (cnt_reg >= limit);
endmodule
`default_nettype wire

// ---- dv/adcc_top_sva.sv ----
// port-level assertions for the converter control block
`default_nettype none
module adcc_top_sva
    import adcc_pkg::*;
#(
    parameter int RC_DIV = RC_DIV_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // watched ports
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic sleepMode,
    input wire logic sampleHold,
    input wire logic bitStrobe,
    input wire logic [12:0] coreResult,
    input wire adcc_analog_t analogCtrl,
    input wire logic irq,
    input wire logic wakeReq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    chk_strobe_gap: assert property (bitStrobe |=> !bitStrobe)
        else $error("bit strobe longer than one cycle");
    chk_sample_end: assert property (sampleHold && bitStrobe |=> !sampleHold)
        else $error("sample phase outlives first period");
    chk_irq_wake: assert property (wakeReq |-> irq)
        else $error("wake without interrupt");
    chk_single_code: assert property (analogCtrl.singleEnded == (analogCtrl.negChannel == CHSN_SINGLE))
        else $error("single-ended flag mismatch");
    chk_range_gate: assert property (!analogCtrl.tempEnable |-> !analogCtrl.tempHighRange)
        else $error("range active while indicator off");
    chk_neg_write: assert property (regWr && regAddr == ADDR_CTRL2 |=> analogCtrl.negChannel == $past(regWdata[3:0]))
        else $error("negative channel not taken");
    chk_pos_write: assert property (regWr && regAddr == ADDR_CTRL0 |=> analogCtrl.posChannel == $past(regWdata[6:2]))
        else $error("positive channel not taken");
    chk_range_write: assert property (regWr && regAddr == ADDR_VREF |=>
        analogCtrl.tempHighRange == ($past(regWdata[5]) && $past(regWdata[4])))
        else $error("range bit not taken");
    cover property ($rose(sampleHold));
    cover property ($rose(irq));
    cover property ($rose(wakeReq));
endmodule
bind adcc_top adcc_top_sva #(.RC_DIV(RC_DIV)) chk_i (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sleepMode(sleepMode),
    .sampleHold(sampleHold), .bitStrobe(bitStrobe), .coreResult(coreResult), .analogCtrl(analogCtrl),
    .irq(irq), .wakeReq(wakeReq));
`default_nettype wire

// ---- dv/adcc_core_model.sv ----
// behavioural converter core stand-in
`default_nettype none
module adcc_core_model (
    // clock and sampling
    input wire logic mclk,
    input wire logic sampleHold,
    // analog stand-in and result
    input wire logic [12:0] level,
    output logic [12:0] coreResult
);
    timeunit 1ns;
    timeprecision 1ns;
    // garbage while sampling, settled result after
    always_ff @(posedge mclk) begin
        coreResult <= sampleHold ? ~level : level;
    end
endmodule
`default_nettype wire

// ---- dv/adcc_top_tb.sv ----
// self-checking bench for the converter control block
`default_nettype none
module adcc_top_tb
    import adcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RCD = 4;
    logic mclk, resetn, regWr, regRd, sleepMode, sampleHold, bitStrobe, irq, wakeReq;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, d;
    logic [12:0] coreResult, level;
    adcc_analog_t analogCtrl;
    int errCount = 0;
    int compares = 0;
    adcc_top #(.RC_DIV(RCD)) dut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sleepMode(sleepMode), .sampleHold(sampleHold),
        .bitStrobe(bitStrobe), .coreResult(coreResult), .analogCtrl(analogCtrl), .irq(irq), .wakeReq(wakeReq));
    adcc_core_model core (.mclk(mclk), .sampleHold(sampleHold), .level(level), .coreResult(coreResult));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic give_verdict;
        $display("compares=%0d errors=%0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic run(input logic [2:0] cs, input int dv, input int nExp, input logic f);
        int n = 0;
        int c0 = 0;
        int cl = 0;
        wr(ADDR_CTRL1, {f, cs, 4'h0});
        wr(ADDR_CTRL0, 8'h11);
        repeat (8) @(posedge mclk);
        wr(ADDR_CTRL0, 8'h13);
        for (int c = 0; c < 15 * dv + 40; c++) begin
            @(posedge mclk);
            #1;
            if (bitStrobe === 1'b1) begin
                if (n == 0) c0 = c;
                cl = c;
                n++;
            end
        end
        chk(n, nExp);
        if (nExp == 15) chk(cl - c0, 14 * dv);
    endtask
    task automatic reset_vals;
        logic [3:0] aTab [6] = '{ADDR_CTRL0, ADDR_CTRL1, ADDR_CTRL2, ADDR_VREF, ADDR_IRQ_STAT, 4'hf};
        logic [7:0] eTab [6] = '{CTRL0_RESET, CTRL1_RESET, CTRL2_RESET, VREF_RESET, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(aTab[i]);
            chk(d, eTab[i]);
        end
    endtask
    task automatic chan;
        logic [1:0] pTab [3] = '{PREF_SUPPLY, PREF_EXT, PREF_FVR};
        adcc_pref_t eTab [3] = '{REF_SUPPLY_SEL, REF_EXT_SEL, REF_FVR_SEL};
        wr(ADDR_CTRL0, {1'b0, CHS_TEMP, 2'b00});
        wr(ADDR_CTRL2, 8'h03);
        chk({analogCtrl.posChannel, analogCtrl.negChannel, analogCtrl.singleEnded}, {CHS_TEMP, 5'h06});
        wr(ADDR_CTRL2, {4'h0, CHSN_SINGLE});
        chk(analogCtrl.singleEnded, 1'b1);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL1, {5'h0, i[0], pTab[i]});
            chk({analogCtrl.posRef, analogCtrl.negRefExt}, {eTab[i], i[0]});
        end
        wr(ADDR_VREF, 8'h30);
        chk({analogCtrl.tempEnable, analogCtrl.tempHighRange}, 2'b11);
        wr(ADDR_VREF, 8'h10);
        chk({analogCtrl.tempEnable, analogCtrl.tempHighRange}, 2'b00);
        rd(ADDR_VREF);
        chk(d, 8'h10);
    endtask
    task automatic temp_conv;
        wr(ADDR_VREF, 8'ha0);
        wr(ADDR_CTRL0, {1'b0, CHS_TEMP, 2'b01});
        chk({analogCtrl.posChannel, analogCtrl.tempEnable, analogCtrl.fixedRefEnable}, {CHS_TEMP, 2'b11});
        repeat (4000) @(posedge mclk);
        rd(ADDR_VREF);
        chk(d, 8'he0);
        wr(ADDR_CTRL0, {1'b0, CHS_TEMP, 2'b11});
        repeat (40) @(posedge mclk);
        rd(ADDR_IRQ_STAT);
        chk(d, 8'h01);
        wr(ADDR_IRQ_CLR, 8'h01);
        wr(ADDR_VREF, 8'h00);
    endtask
    task automatic conv_all;
        logic [2:0] cTab [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
        int dTab [8] = '{2, 4, 8, 16, 32, 64, RCD, RCD};
        for (int i = 0; i < 8; i++) begin
            level <= i[0] ? 13'h1fff : 13'h0933;
            run(cTab[i], dTab[i], 15, i[0]);
            rd(ADDR_RES_HI);
            chk(d, i[0] ? 8'hff : 8'h93);
            rd(ADDR_RES_LO);
            chk(d, i[0] ? 8'hff : 8'h30);
            rd(ADDR_CTRL0);
            chk(d, 8'h11);
            rd(ADDR_IRQ_STAT);
            chk(d, 8'h01);
            wr(ADDR_IRQ_CLR, 8'h01);
        end
    endtask
    task automatic irq_sleep;
        wr(ADDR_IRQ_EN, 8'h01);
        sleepMode <= 1'b1;
        run(3'h3, RCD, 15, 1'b0);
        chk({irq, wakeReq}, 2'b11);
        wr(ADDR_IRQ_CLR, 8'h01);
        chk({irq, wakeReq}, 2'b00);
        run(3'h2, 32, 0, 1'b0);
        wr(ADDR_CTRL0, 8'h00);
        sleepMode <= 1'b0;
        wr(ADDR_IRQ_EN, 8'h00);
        run(3'h0, 2, 15, 1'b0);
        rd(ADDR_IRQ_STAT);
        chk({d, irq}, 9'h002);
    endtask
    initial begin
        {regAddr, regWdata, regWr, regRd, sleepMode, resetn} = '0;
        level = '0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        reset_vals();
        chan();
        temp_conv();
        conv_all();
        irq_sleep();
        give_verdict();
    end
    initial begin
        #1000000;
        errCount++;
        give_verdict();
    end
endmodule
`default_nettype wire
